// ### src/external_data_bus_interface.sv
// multiplexed 8-bit external data memory bus master
module external_data_bus_interface (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // mode controls from the core
  input wire logic stretch_select_i,
  input wire logic double_speed_i,
  // core request port
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  // external bus pins
  output logic [7:0] addr_high_o,
  input wire logic [7:0] addr_data_low_i,
  output logic [7:0] addr_data_low_o,
  output logic addr_data_low_oe_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o
);
  import ext_bus_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  bus_phase_e phase;
  logic tick;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic we_q;
  logic stretch_q;
  logic dspeed_q;
  logic [4:0] strobe_left;
  logic [7:0] din_meta;
  logic [7:0] din_sync;
  logic start;

  assign start = (phase == PH_IDLE) && tick && req_i;

  // core clock period enable
  core_tick_gen u_tick (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .double_speed_i(double_speed_i),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      din_meta <= 8'h00;
      din_sync <= 8'h00;
    end else begin
      din_meta <= addr_data_low_i;
      din_sync <= din_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request capture, held for the whole cycle; the tick rate uses live double_speed_i, not dspeed_q
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      stretch_q <= 1'b0;
      dspeed_q <= 1'b0;
    end else if (start) begin
      addr_q <= addr_i;
      wdata_q <= wdata_i;
      we_q <= we_i;
      stretch_q <= stretch_select_i;
      dspeed_q <= double_speed_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer: addr, setup, strobe, hold, one core period each but strobe
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase <= PH_IDLE;
      strobe_left <= 5'h00;
    end else if (tick) begin
      case (phase)
        PH_IDLE: begin
          if (req_i) begin
            phase <= PH_ADDR;
          end
        end
        PH_ADDR: begin
          phase <= PH_SETUP;
        end
        PH_SETUP: begin
          phase <= PH_STROBE;
          strobe_left <= strobe_ticks(stretch_q) - 5'h01; // [RULE8]
        end
        PH_STROBE: begin
          if (strobe_left == 5'h00) begin
            phase <= PH_HOLD;
          end else begin
            strobe_left <= strobe_left - 5'h01;
          end
        end
        PH_HOLD: begin
          phase <= PH_IDLE; // [RULE6]
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address pins and latch strobe
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_high_o <= ADDR_HIGH_RST;
      ale_o <= 1'b0;
    end else if (tick) begin
      if (start) begin
        addr_high_o <= addr_i[15:8]; // [RULE1]
      end
      ale_o <= start; // [RULE3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared low-byte lines: address first, then write data or released for read
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_data_low_o <= LOW_PORT_RST;
      addr_data_low_oe_o <= 1'b0;
    end else if (tick) begin
      if (start) begin
        addr_data_low_o <= addr_i[7:0]; // [RULE1]
        addr_data_low_oe_o <= 1'b1;
      end else if (phase == PH_ADDR) begin
        addr_data_low_o <= we_q ? wdata_q : LOW_PORT_RST; // [RULE2]
        addr_data_low_oe_o <= we_q; // [RULE9]
      end else if (phase == PH_HOLD) begin
        addr_data_low_oe_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read and write strobes
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
    end else if (tick) begin
      if (phase == PH_SETUP) begin
        rd_n_o <= we_q; // [RULE4]
        wr_n_o <= !we_q; // [RULE5]
      end else if (phase == PH_STROBE && strobe_left == 5'h00) begin
        rd_n_o <= 1'b1;
        wr_n_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // core answer: read data taken as the read strobe rises, done pulse at end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      if (tick && phase == PH_STROBE && strobe_left == 5'h00 && !we_q) begin
        rdata_o <= din_sync; // [RULE9]
      end
      done_o <= tick && (phase == PH_HOLD);
      if (start) begin
        busy_o <= 1'b1;
      end else if (tick && phase == PH_HOLD) begin
        busy_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks: helper counters in oscillator periods
  logic [7:0] low_len;
  logic [7:0] cyc_len;
  logic strobe_n;

  assign strobe_n = rd_n_o & wr_n_o;

  // count periods the strobe is low and periods since the latch strobe rose
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_len <= 8'h00;
      cyc_len <= 8'h00;
    end else begin
      low_len <= strobe_n ? 8'h00 : low_len + 8'h01;
      cyc_len <= (tick && start) ? 8'h01 : cyc_len + 8'h01;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_ale_addr: assert property (ale_o |-> addr_data_low_oe_o && addr_data_low_o == addr_q[7:0]) // [RULE3]
    else $error("low address not valid while latch strobe high");
  chk_high_addr: assert property (busy_o |-> addr_high_o == addr_q[15:8]) // [RULE1]
    else $error("high address byte wrong during cycle");
  chk_wr_data: assert property (!wr_n_o |-> addr_data_low_oe_o && addr_data_low_o == wdata_q) // [RULE2]
    else $error("write data not on shared lines during write strobe");
  chk_rd_release: assert property (!rd_n_o |-> !addr_data_low_oe_o && we_q == 1'b0) // [RULE9]
    else $error("shared lines driven during read strobe");
  // write strobe only on writes and never together with the read strobe
  chk_strobe_excl: assert property (!wr_n_o |-> we_q && rd_n_o) // [RULE5]
    else $error("wrong strobe for the access");
  // low_len already holds the full low count at the edge that sees the rise
  chk_strobe_width: assert property ($rose(strobe_n) |-> // [RULE8]
      low_len == ticks_to_osc(strobe_ticks(stretch_q), dspeed_q))
    else $error("strobe width wrong");
  chk_cycle_len: assert property ($rose(done_o) && !stretch_q |-> // [RULE6]
      cyc_len == ticks_to_osc(CYCLE_TICKS, dspeed_q) + 8'h01)
    else $error("bus cycle length wrong");
  chk_rd_sample: assert property ($rose(rd_n_o) |-> rdata_o == $past(din_sync)) // [RULE9]
    else $error("read data not sampled at strobe rise");
  // latch strobe spans two clocks in standard mode, so look one clock past each high sample
  chk_ale_first: assert property (ale_o |-> rd_n_o && wr_n_o ##1 rd_n_o && wr_n_o) // [RULE3]
    else $error("latch strobe overlaps strobe");

  cov_read: cover property ($rose(rd_n_o) && !stretch_q);
  cov_write: cover property ($rose(wr_n_o) && !stretch_q);
  cov_stretch: cover property ($rose(strobe_n) && stretch_q);
  cov_dspeed: cover property ($rose(done_o) && dspeed_q);
endmodule // external_data_bus_interface

// ### inc/ext_bus_pkg.sv
// constants and types shared by the external data bus interface
// Function
// [RULE1] During an access the low byte of the address goes out on the low-byte port and the high byte on the high-byte port.
// [RULE2] Data shares the low-byte port lines with the low address byte, address first and data afterwards.
// [RULE3] The address latch strobe marks when a valid low address stands on the shared lines, so outside logic can latch it.
// [RULE4] A read asserts the active-low read strobe, the alternative function of bit 7 of the third port.
// [RULE5] A write asserts the active-low write strobe, the alternative function of bit 6 of the third port.
// [RULE6] An unstretched read or write bus cycle lasts exactly six core clock periods.
// [RULE7] A bus cycle is twelve oscillator periods in standard mode and six in double-speed mode.
// [RULE8] With stretch select set, the read and write strobes widen from 3 to 15 core clock periods.
// [RULE9] A read releases the shared lines after the address phase and samples data as the read strobe rises.
// [RULE10] External memory drives the shared lines only while read strobe is low and takes write data by the write strobe's rise.
package ext_bus_pkg;
  // bus cycle shape, counted in core clock periods
  localparam logic [4:0] CYCLE_TICKS = 5'h06;
  localparam logic [4:0] STROBE_TICKS = 5'h03;
  localparam logic [4:0] STRETCH_TICKS = 5'h0F;
  // oscillator periods per core clock period
  localparam logic [1:0] OSC_PER_TICK_STD = 2'h2;
  localparam logic [1:0] OSC_PER_TICK_DSPEED = 2'h1;
  // reset values of the pins
  localparam logic [7:0] ADDR_HIGH_RST = 8'hFF;
  localparam logic [7:0] LOW_PORT_RST = 8'hFF;

  // one-hot bus cycle phases
  typedef enum logic [4:0] {
    PH_IDLE = 5'b0_0001,
    PH_ADDR = 5'b0_0010,
    PH_SETUP = 5'b0_0100,
    PH_STROBE = 5'b0_1000,
    PH_HOLD = 5'b1_0000
  } bus_phase_e;

  // strobe width in core clock periods for the chosen stretch setting
  function automatic logic [4:0] strobe_ticks(input logic stretch);
    strobe_ticks = stretch ? STRETCH_TICKS : STROBE_TICKS;
  endfunction

  // oscillator periods for a number of core clock periods
  function automatic logic [7:0] ticks_to_osc(input logic [4:0] ticks, input logic dspeed);
    ticks_to_osc = dspeed ? {3'h0, ticks} : {2'h0, ticks, 1'b0};
  endfunction
endpackage

// ### src/core_tick_gen.sv
// core clock period enable from the oscillator clock
module core_tick_gen (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // mode
  input wire logic double_speed_i,
  // enable pulse
  output logic tick_o
);
  import ext_bus_pkg::*;

  logic [1:0] div_cnt;

  // count oscillator periods, pulse once per core clock period
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt <= 2'h0;
      tick_o <= 1'b0;
    end else begin
      if (div_cnt + 2'h1 >= (double_speed_i ? OSC_PER_TICK_DSPEED : OSC_PER_TICK_STD)) begin
        div_cnt <= 2'h0;
        tick_o <= 1'b1; // [RULE7]
      end else begin
        div_cnt <= div_cnt + 2'h1;
        tick_o <= 1'b0;
      end
    end
  end
endmodule // core_tick_gen

// ### verif/ext_mem_model.sv
// behavioural external data memory on the multiplexed bus
module ext_mem_model (
  // clock
  input wire logic clk_i,
  // bus pins from the device
  input wire logic [7:0] addr_high_i,
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  // resolved shared lines
  output logic [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535];
  logic [7:0] lo_addr = 8'h00;
  logic [7:0] last = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // latch the low address while the strobe is high
  always @(posedge clk_i) begin
    if (ale_i) lo_addr <= dev_data_i;
  end
  // take write data each cycle the write strobe is low
  always @(posedge clk_i) begin
    if (!wr_n_i) mem[{addr_high_i, lo_addr}] <= dev_data_i;
  end
  // released lines show a toggling pattern, never the old value
  always @(posedge clk_i) begin
    last <= pin_o;
  end
  // drive data only while the read strobe is low
  assign pin_o = dev_oe_i ? dev_data_i : (!rd_n_i ? mem[{addr_high_i, lo_addr}] : ~last);
endmodule // ext_mem_model

// ### verif/tb_top.sv
// self-checking bench for the external data bus interface
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ext_bus_pkg::*;
  logic core_clk_i, arst_n_i, stretch_select_i, double_speed_i, req_i, we_i;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, rdata_o, addr_high_o, pin, addr_data_low_o, rd;
  logic busy_o, done_o, addr_data_low_oe_o, ale_o, rd_n_o, wr_n_o;
  int n_mismatch = 0;
  int total_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  external_data_bus_interface dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .stretch_select_i(stretch_select_i), .double_speed_i(double_speed_i), .req_i(req_i),
    .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o), .addr_high_o(addr_high_o), .addr_data_low_i(pin),
    .addr_data_low_o(addr_data_low_o), .addr_data_low_oe_o(addr_data_low_oe_o),
    .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));
  ext_mem_model mem (.clk_i(core_clk_i), .addr_high_i(addr_high_o),
    .dev_data_i(addr_data_low_o), .dev_oe_i(addr_data_low_oe_o), .ale_i(ale_o),
    .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .pin_o(pin));
  ////////////////////////////////////////////////////////////////////////////////
  // compare one value
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // print counts and verdict, then end
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one bus cycle, judging pins, strobe width and cycle length
  task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
                        input logic st, input logic ds, output logic [7:0] r);
    int k;
    int lo;
    int mul;
    int cyc;
    mul = ds ? 1 : 2;
    cyc = (st ? STRETCH_TICKS - STROBE_TICKS + CYCLE_TICKS : CYCLE_TICKS) * mul;
    lo = 0;
    stretch_select_i <= st;
    double_speed_i <= ds;
    we_i <= w;
    addr_i <= a;
    wdata_i <= d;
    req_i <= 1'b1;
    for (k = 0; k < 64 && busy_o !== 1'b1; k++) @(posedge core_clk_i);
    if (k == 64) begin
      chk(16'h0000, 16'h0001);
      report_and_stop();
    end
    req_i <= 1'b0;
    for (k = 1; k < 64 && done_o !== 1'b1; k++) begin
      if (k == 1) begin
        chk({ale_o, addr_data_low_oe_o, 6'h00, addr_data_low_o},
            {2'h3, 6'h00, a[7:0]});
        chk({8'h00, addr_high_o}, {8'h00, a[15:8]});
      end
      if ((w ? wr_n_o : rd_n_o) === 1'b0) begin
        lo++;
        chk({w ? rd_n_o : wr_n_o, addr_data_low_oe_o}, {1'b1, w});
        if (w) chk({8'h00, addr_data_low_o}, {8'h00, d});
      end
      @(posedge core_clk_i);
    end
    if (k == 64) begin
      chk(16'h0000, 16'h0002);
      report_and_stop();
    end
    chk(16'(lo), 16'((st ? STRETCH_TICKS : STROBE_TICKS) * mul));
    // done is seen one clock after the hold tick that ends the cycle
    chk(16'(k - 1), 16'(cyc));
    r = rdata_o;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // pins idle at their reset levels
  task automatic reset_values();
    chk({ale_o, rd_n_o, wr_n_o, addr_data_low_oe_o, busy_o, done_o}, 16'h0018);
    chk({addr_high_o, addr_data_low_o}, 16'hFFFF);
  endtask
  // standard mode, plain strobes: write then read back
  task automatic std_write_read();
    access(1'b1, 16'h12A5, 8'h3C, 1'b0, 1'b0, rd);
    access(1'b0, 16'h12A5, 8'h00, 1'b0, 1'b0, rd);
    chk({8'h00, rd}, 16'h003C);
  endtask
  // stretched strobes in double speed, then in standard mode
  task automatic dspeed_stretch();
    access(1'b1, 16'hFE01, 8'hC3, 1'b1, 1'b1, rd);
    access(1'b0, 16'hFE01, 8'h00, 1'b1, 1'b1, rd);
    chk({8'h00, rd}, 16'h00C3);
    access(1'b1, 16'h7E81, 8'h96, 1'b1, 1'b0, rd);
    access(1'b0, 16'h7E81, 8'h00, 1'b1, 1'b0, rd);
    chk({8'h00, rd}, 16'h0096);
  endtask
  // back-to-back cycles with mirrored address bytes
  task automatic dspeed_back_to_back();
    access(1'b1, 16'h00FF, 8'h5A, 1'b0, 1'b1, rd);
    access(1'b1, 16'hFF00, 8'hA5, 1'b0, 1'b1, rd);
    access(1'b0, 16'h00FF, 8'h00, 1'b0, 1'b1, rd);
    chk({8'h00, rd}, 16'h005A);
    access(1'b0, 16'hFF00, 8'h00, 1'b0, 1'b1, rd);
    chk({8'h00, rd}, 16'h00A5);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock at 125 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // reset, then the scenarios
  initial begin
    arst_n_i = 1'b0;
    stretch_select_i = 1'b0;
    double_speed_i = 1'b0;
    req_i = 1'b0;
    we_i = 1'b0;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    repeat (8) @(posedge core_clk_i);
    reset_values();
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    std_write_read();
    dspeed_stretch();
    dspeed_back_to_back();
    report_and_stop();
  end
endmodule // tb_top
